/* File: jdac_map.svh */
// register offsets, field positions, reset values and timing constants
`ifndef JDAC_MAP_SVH
`define JDAC_MAP_SVH

`define JDAC_REG_EN_ONE 8'h1d
`define JDAC_REG_EN_TWO 8'h1e
`define JDAC_REG_RSVD 8'h1f
`define JDAC_REG_UNLOCK 8'h66
`define JDAC_REG_BTNCLK 8'h6f

`define JDAC_EN_ONE_RST 8'h00
`define JDAC_EN_TWO_RST 8'h01
`define JDAC_UNLOCK_RST 8'h00
`define JDAC_BTNCLK_RST 8'h00
`define JDAC_READ_ZERO 8'h00
`define JDAC_UNLOCK_KEY 8'hf1

`define JDAC_HP_HI 7
`define JDAC_HP_LO 6
`define JDAC_SLEW_BIT 5
`define JDAC_FAST_BIT 3
`define JDAC_THR_BIT 2
`define JDAC_AUTO_HI 1
`define JDAC_AUTO_LO 0

`define JDAC_MODE_HOST 2'h0
`define JDAC_MODE_AUTO_SLP 2'h1
`define JDAC_MODE_AUTO_ALL 2'h2
`define JDAC_MODE_BAD 2'h3

`define JDAC_CLK_KHZ 20000
`define JDAC_SLOW_POLL_MS 2000
`define JDAC_FAST_POLL_MS 333
`define JDAC_POLL_W 26

`define JDAC_DEV_ADDR 7'h40
`define JDAC_BYTE_BITS 4'h8

`endif

/* File: jdac_pkg.sv */
// types shared by the jack detect control block
package jdac_pkg;
	typedef enum logic [2:0] {
		JDAC_I2C_IDLE,
		JDAC_I2C_ADDR,
		JDAC_I2C_PTR,
		JDAC_I2C_WDATA,
		JDAC_I2C_ACK,
		JDAC_I2C_RDATA,
		JDAC_I2C_MACK
	} jdac_i2c_state_t;
endpackage : jdac_pkg

/* File: jdac_i2c.sv */
// i2c target that turns bus transfers into register strobes
`timescale 1ns/1ns
`include "jdac_map.svh"
module jdac_i2c import jdac_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = `JDAC_DEV_ADDR
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// gate from supply monitor
	input wire logic bus_enable,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// register side
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	jdac_i2c_state_t st;
	jdac_i2c_state_t ack_next;
	logic [7:0] sh;
	logic [3:0] cnt;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] & ~scl_d;
	assign scl_fall = ~scl_sync[1] & scl_d;
	assign start_seen = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_seen = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	// open drain: only ever pulls low
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= JDAC_I2C_IDLE;
			ack_next <= JDAC_I2C_IDLE;
			sh <= 8'h00;
			cnt <= 4'h0;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_addr <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (!bus_enable) begin
				st <= JDAC_I2C_IDLE;
				sda_oe <= 1'b0;
			end else if (start_seen) begin
				st <= JDAC_I2C_ADDR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_seen) begin
				st <= JDAC_I2C_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st)
				JDAC_I2C_ADDR, JDAC_I2C_PTR, JDAC_I2C_WDATA: begin
					if (scl_rise) begin
						sh <= {sh[6:0], sda_sync[1]};
						cnt <= cnt + 4'h1;
					end else if (scl_fall && cnt == `JDAC_BYTE_BITS) begin
						st <= JDAC_I2C_ACK;
						sda_oe <= 1'b1;
						if (st == JDAC_I2C_ADDR) begin
							if (sh[7:1] != DEV_ADDR) begin
								st <= JDAC_I2C_IDLE;
								sda_oe <= 1'b0;
							end
							ack_next <= sh[0] ? JDAC_I2C_RDATA : JDAC_I2C_PTR;
						end else if (st == JDAC_I2C_PTR) begin
							rd_addr <= sh;
							ack_next <= JDAC_I2C_WDATA;
						end else begin
							wr_stb <= 1'b1;
							wr_addr <= rd_addr;
							wr_data <= sh;
							rd_addr <= rd_addr + 8'h01;
							ack_next <= JDAC_I2C_WDATA;
						end
					end
				end
				JDAC_I2C_ACK: begin
					if (scl_fall) begin
						cnt <= 4'h0;
						st <= ack_next;
						if (ack_next == JDAC_I2C_RDATA) begin
							sh <= {rd_data[6:0], 1'b0};
							sda_oe <= ~rd_data[7];
							cnt <= 4'h1;
							rd_addr <= rd_addr + 8'h01;
						end else begin
							sda_oe <= 1'b0;
						end
					end
				end
				JDAC_I2C_RDATA: begin
					if (scl_fall) begin
						if (cnt == `JDAC_BYTE_BITS) begin
							sda_oe <= 1'b0;
							st <= JDAC_I2C_MACK;
						end else begin
							sda_oe <= ~sh[7];
							sh <= {sh[6:0], 1'b0};
							cnt <= cnt + 4'h1;
						end
					end
				end
				JDAC_I2C_MACK: begin
					// nack ends the read; wait for stop or restart
					if (scl_rise) begin
						st <= sda_sync[1] ? JDAC_I2C_IDLE : JDAC_I2C_ACK;
						ack_next <= JDAC_I2C_RDATA;
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule : jdac_i2c

/* File: jdac_ctrl.sv */
// jack detect poll, class-g select, automatic enable and button clock regs
`timescale 1ns/1ns
`include "jdac_map.svh"
module jdac_ctrl import jdac_pkg::*; #(
	parameter logic [`JDAC_POLL_W-1:0] SLOW_POLL_CYC =
		`JDAC_POLL_W'(`JDAC_SLOW_POLL_MS * `JDAC_CLK_KHZ),
	parameter logic [`JDAC_POLL_W-1:0] FAST_POLL_CYC =
		`JDAC_POLL_W'(`JDAC_FAST_POLL_MS * `JDAC_CLK_KHZ)
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// supply and jack switch pins
	input wire logic core_supply_ok,
	input wire logic mic_supply,
	input wire logic jack_switch_terminal,
	input wire logic jack_switch_closed,
	// bits held in other control registers
	input wire logic power_down_request,
	input wire logic sleep_request,
	// detection engine
	input wire logic [7:0] det_en_one,
	input wire logic [1:0] det_en_hp,
	output logic detect_start,
	// block controls
	output logic [7:0] blk_en_one,
	output logic [1:0] blk_en_hp,
	output logic vol_slew_disable,
	output logic classg_threshold_select,
	output logic low_power,
	output logic [7:0] button_clock_setting
);
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic sup_ok_d;
	logic sw_closed_d;
	logic sup_ok;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] en_one_host;
	logic [7:0] en_two;
	logic [7:0] clock_unlock_key;
	logic [1:0] mode;
	logic auto_mode;
	logic auto_run;
	logic [7:0] eff_one;
	logic [1:0] eff_hp;
	logic [7:0] rep_one;
	logic [1:0] rep_hp;
	logic [`JDAC_POLL_W-1:0] poll_cnt;
	logic [`JDAC_POLL_W-1:0] poll_limit;
	logic poll_tick;

	// pins pass two flops; only the second is read
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			sup_ok_d <= 1'b0;
			sw_closed_d <= 1'b0;
		end else begin
			pin_s1 <= {jack_switch_closed, jack_switch_terminal,
				mic_supply, core_supply_ok};
			pin_s2 <= pin_s1;
			sup_ok_d <= sup_ok;
			sw_closed_d <= pin_s2[3];
		end
	end

	assign sup_ok = pin_s2[0] & pin_s2[1];

	jdac_i2c u_i2c (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.bus_enable(sup_ok),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	assign mode = en_two[`JDAC_AUTO_HI:`JDAC_AUTO_LO];
	assign auto_mode = (mode != `JDAC_MODE_HOST);
	// mode 01 needs sleep clear and the power bit at its run level
	assign auto_run = (mode == `JDAC_MODE_AUTO_ALL) ||
		(mode == `JDAC_MODE_AUTO_SLP && !sleep_request &&
		power_down_request);
	assign eff_one = auto_run ? det_en_one : `JDAC_READ_ZERO;
	assign eff_hp = auto_run ? det_en_hp : 2'h0;
	assign rep_one = auto_mode ? eff_one : en_one_host;
	assign rep_hp = auto_mode ? eff_hp : en_two[`JDAC_HP_HI:`JDAC_HP_LO];

	always_comb begin
		case (rd_addr)
		`JDAC_REG_EN_ONE: rd_data = rep_one;
		`JDAC_REG_EN_TWO: rd_data = {rep_hp, en_two[`JDAC_SLEW_BIT:0]};
		`JDAC_REG_UNLOCK: rd_data = clock_unlock_key;
		`JDAC_REG_BTNCLK: rd_data = button_clock_setting;
		default: rd_data = `JDAC_READ_ZERO;
		endcase
	end

	// only the async reset clears these; supply drops leave them alone
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			en_one_host <= `JDAC_EN_ONE_RST;
			en_two <= `JDAC_EN_TWO_RST;
		end else if (wr_stb) begin
			if (wr_addr == `JDAC_REG_EN_ONE && !auto_mode)
				en_one_host <= wr_data;
			if (wr_addr == `JDAC_REG_EN_TWO) begin
				en_two[`JDAC_SLEW_BIT:`JDAC_THR_BIT] <=
					wr_data[`JDAC_SLEW_BIT:`JDAC_THR_BIT];
				if (!auto_mode)
					en_two[`JDAC_HP_HI:`JDAC_HP_LO] <=
						wr_data[`JDAC_HP_HI:`JDAC_HP_LO];
				// invalid code keeps the old mode
				if (wr_data[`JDAC_AUTO_HI:`JDAC_AUTO_LO] != `JDAC_MODE_BAD)
					en_two[`JDAC_AUTO_HI:`JDAC_AUTO_LO] <=
						wr_data[`JDAC_AUTO_HI:`JDAC_AUTO_LO];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clock_unlock_key <= `JDAC_UNLOCK_RST;
			button_clock_setting <= `JDAC_BTNCLK_RST;
		end else if (wr_stb) begin
			if (wr_addr == `JDAC_REG_UNLOCK)
				clock_unlock_key <= wr_data;
			if (wr_addr == `JDAC_REG_BTNCLK &&
				clock_unlock_key == `JDAC_UNLOCK_KEY)
				button_clock_setting <= wr_data;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			blk_en_one <= `JDAC_EN_ONE_RST;
			blk_en_hp <= 2'h0;
			vol_slew_disable <= 1'b0;
			classg_threshold_select <= 1'b0;
			low_power <= 1'b0;
		end else begin
			blk_en_one <= rep_one;
			blk_en_hp <= rep_hp;
			vol_slew_disable <= en_two[`JDAC_SLEW_BIT];
			classg_threshold_select <= en_two[`JDAC_THR_BIT];
			low_power <= (mode == `JDAC_MODE_AUTO_SLP) &&
				!power_down_request;
		end
	end

	assign poll_limit = en_two[`JDAC_FAST_BIT] ? FAST_POLL_CYC :
		SLOW_POLL_CYC;
	assign poll_tick = (poll_cnt >= poll_limit - `JDAC_POLL_W'(1));

	// timer held while the switch works or supplies are missing
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			poll_cnt <= '0;
		else if (!sup_ok || pin_s2[2] || poll_tick)
			poll_cnt <= '0;
		else
			poll_cnt <= poll_cnt + `JDAC_POLL_W'(1);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			detect_start <= 1'b0;
		else
			detect_start <= sup_ok && (
				(!pin_s2[2] && poll_tick) ||
				(pin_s2[2] && pin_s2[3] && !sw_closed_d) ||
				!sup_ok_d);
	end
endmodule : jdac_ctrl

/* File: jdac_host.sv */
// i2c controller model standing in for the host processor
`timescale 1ns/1ns
`include "jdac_map.svh"
module jdac_host (
	// clock
	input wire logic ref_clk,
	// bus lines, sda released means pulled high
	input wire logic sda_ln,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// six cycles keep each phase above the 250 ns minimum
	task automatic hw();
		repeat (6) @(negedge ref_clk);
	endtask : hw
	task automatic bit_io(input logic b, output logic q);
		sda = b;
		hw();
		scl = 1'b1;
		hw();
		q = sda_ln;
		scl = 1'b0;
		hw();
	endtask : bit_io
	task automatic start();
		sda = 1'b1;
		hw();
		scl = 1'b1;
		hw();
		sda = 1'b0;
		hw();
		scl = 1'b0;
		hw();
	endtask : start
	task automatic stop();
		sda = 1'b0;
		hw();
		scl = 1'b1;
		hw();
		sda = 1'b1;
		hw();
	endtask : stop
	// single byte reads only, so the last bit is always released
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, n);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic [2:0] n;
		start();
		xfer({`JDAC_DEV_ADDR, 1'b0}, q, n[0]);
		xfer(a, q, n[1]);
		xfer(d, q, n[2]);
		stop();
		ok = (n == 3'b000);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic [2:0] n;
		logic x;
		start();
		xfer({`JDAC_DEV_ADDR, 1'b0}, q, n[0]);
		xfer(a, q, n[1]);
		start();
		xfer({`JDAC_DEV_ADDR, 1'b1}, q, n[2]);
		xfer(8'hff, d, x);
		stop();
		ok = (n == 3'b000);
	endtask : rd
endmodule : jdac_host

/* File: jdac_ctrl_sva.sv */
// assertions on the jack detect control ports
`timescale 1ns/1ns
module jdac_ctrl_sva #(
	parameter logic [25:0] SLOW_POLL_CYC = 26'd40
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// pins and controls
	input wire logic sda_oe,
	input wire logic core_supply_ok,
	input wire logic mic_supply,
	input wire logic jack_switch_terminal,
	input wire logic jack_switch_closed,
	input wire logic power_down_request,
	input wire logic detect_start,
	input wire logic [7:0] blk_en_one,
	input wire logic [1:0] blk_en_hp,
	input wire logic low_power,
	input wire logic [7:0] button_clock_setting
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic up;
	logic [26:0] gap;
	logic [3:0] calm;
	assign up = core_supply_ok && mic_supply;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			gap <= '0;
		else if (detect_start || jack_switch_terminal || !up)
			gap <= '0;
		else
			gap <= gap + 27'd1;
	end
	// margin covers pin sync and the switch edge detect delay
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			calm <= '0;
		else if (!jack_switch_terminal || !up || $changed(jack_switch_closed))
			calm <= '0;
		else if (calm != 4'hf)
			calm <= calm + 4'h1;
	end
	sequence s_gone;
		!(core_supply_ok && mic_supply) [*5];
	endsequence
	sequence s_mic_back;
		core_supply_ok && $rose(mic_supply);
	endsequence
	property p_gated;
		s_gone |-> !sda_oe && !detect_start;
	endproperty
	property p_pulse;
		detect_start |=> !detect_start;
	endproperty
	property p_poll;
		gap <= 27'(SLOW_POLL_CYC) + 27'd8;
	endproperty
	property p_quiet;
		calm == 4'hf |-> !detect_start;
	endproperty
	property p_rerun;
		s_mic_back |-> ##[1:8] detect_start;
	endproperty
	property p_retain;
		(!mic_supply) [*4] |=> $stable(button_clock_setting);
	endproperty
	property p_lp_cause;
		low_power |-> !$past(power_down_request);
	endproperty
	property p_lp_off;
		low_power |-> blk_en_one == 8'h00 && blk_en_hp == 2'h0;
	endproperty
	a_gated: assert property (p_gated)
		else $error("active without supplies");
	a_pulse: assert property (p_pulse)
		else $error("detect pulse too long");
	a_poll: assert property (p_poll)
		else $error("poll interval too long");
	a_quiet: assert property (p_quiet)
		else $error("poll while switch works");
	a_rerun: assert property (p_rerun)
		else $error("no rerun after mic return");
	a_retain: assert property (p_retain)
		else $error("register lost on mic drop");
	a_lp_cause: assert property (p_lp_cause)
		else $error("low power without shutdown");
	a_lp_off: assert property (p_lp_off)
		else $error("enables on in low power");
endmodule : jdac_ctrl_sva
bind jdac_ctrl jdac_ctrl_sva #(.SLOW_POLL_CYC(SLOW_POLL_CYC)) jdac_ctrl_sva_i (
	.ref_clk, .sys_rst, .sda_oe, .core_supply_ok, .mic_supply,
	.jack_switch_terminal, .jack_switch_closed, .power_down_request,
	.detect_start, .blk_en_one, .blk_en_hp, .low_power,
	.button_clock_setting);

/* File: jdac_ctrl_tb.sv */
// self-checking bench for the jack detect control block
`timescale 1ns/1ns
`include "jdac_map.svh"
module jdac_ctrl_tb;
	localparam int SLOW = 40;
	localparam int FAST = 12;
	logic ref_clk, sys_rst, scl_in, sda_in, sda_out, sda_oe, h_sda, ok;
	logic core_supply_ok, mic_supply, jack_switch_terminal;
	logic jack_switch_closed, power_down_request, sleep_request;
	logic detect_start, vol_slew_disable, classg_threshold_select, low_power;
	logic [7:0] det_en_one, blk_en_one, button_clock_setting, r;
	logic [1:0] det_en_hp, blk_en_hp;
	int mismatches, checked, cyc, pulses, last, n;
	logic [15:0] tab [5] = '{16'h1e01, 16'h1f00, 16'h6600, 16'h6f00, 16'h1d00};
	assign sda_in = h_sda & (!sda_oe | sda_out);
	jdac_host jdac_host_i (.ref_clk, .sda_ln(sda_in), .scl(scl_in), .sda(h_sda));
	jdac_ctrl #(.SLOW_POLL_CYC(26'(SLOW)), .FAST_POLL_CYC(26'(FAST))) jdac_ctrl_i (
		.ref_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe,
		.core_supply_ok, .mic_supply, .jack_switch_terminal,
		.jack_switch_closed, .power_down_request, .sleep_request,
		.det_en_one, .det_en_hp, .detect_start, .blk_en_one, .blk_en_hp,
		.vol_slew_disable, .classg_threshold_select, .low_power,
		.button_clock_setting);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (detect_start === 1'b1) begin
			pulses++;
			last = cyc;
		end
	end
	function automatic logic [9:0] exp_en(input logic [1:0] m,
		input logic [9:0] h);
		if (m == `JDAC_MODE_HOST)
			return h;
		if (m == `JDAC_MODE_AUTO_SLP && (sleep_request || !power_down_request))
			return 10'h000;
		return {det_en_hp, det_en_one};
	endfunction : exp_en
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		jdac_host_i.wr(a, d, ok);
	endtask : w
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		jdac_host_i.rd(a, r, ok);
		chk({1'b0, ok, r}, {2'b01, e});
	endtask : rc
	// measured between two later pulses, so a part count is not seen
	task automatic gap(input int e);
		int n0, t0;
		n0 = pulses;
		while (pulses == n0) @(negedge ref_clk);
		t0 = last;
		while (pulses == n0 + 1) @(negedge ref_clk);
		chk(10'(last - t0), 10'(e));
	endtask : gap
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (80000) @(posedge ref_clk);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h2dcaf992));
		{core_supply_ok, mic_supply, jack_switch_terminal} = 3'b111;
		{jack_switch_closed, sleep_request, power_down_request} = 3'b001;
		{det_en_hp, det_en_one} = 10'h000;
		sys_rst = 1'b1;
		repeat (3) @(negedge ref_clk);
		sys_rst = 1'b0;
		chk(10'({classg_threshold_select, low_power, button_clock_setting}),
			10'h000);
		repeat (20) @(negedge ref_clk);
		foreach (tab[i]) rc(tab[i][15:8], tab[i][7:0]);
		for (int k = 0; k < 4; k++) begin
			{det_en_hp, det_en_one} = 10'($urandom);
			{sleep_request, power_down_request} = 2'(k);
			w(`JDAC_REG_EN_ONE, 8'($urandom));
			chk({blk_en_hp, blk_en_one}, exp_en(2'h1, 10'h0));
			chk(10'(low_power), 10'(!power_down_request));
			rc(`JDAC_REG_EN_ONE, 8'(exp_en(2'h1, 10'h0)));
		end
		{sleep_request, power_down_request} = 2'b10;
		w(`JDAC_REG_EN_TWO, 8'h2e);
		chk(10'({vol_slew_disable, classg_threshold_select, low_power}),
			10'h006);
		chk({blk_en_hp, blk_en_one}, exp_en(2'h2, 10'h0));
		w(`JDAC_REG_EN_TWO, 8'h2f);
		rc(`JDAC_REG_EN_TWO, {det_en_hp, 6'h2e});
		jack_switch_terminal = 1'b0;
		gap(FAST);
		w(`JDAC_REG_EN_TWO, 8'h26);
		gap(SLOW);
		jack_switch_terminal = 1'b1;
		repeat (10) @(negedge ref_clk);
		n = pulses;
		repeat (100) @(negedge ref_clk);
		chk(10'(pulses), 10'(n));
		jack_switch_closed = 1'b1;
		repeat (12) @(negedge ref_clk);
		chk(10'(pulses), 10'(n + 1));
		w(`JDAC_REG_EN_TWO, 8'hc4);
		// mode was still automatic when this write landed, so hp stays off
		chk(10'(blk_en_hp), 10'h000);
		w(`JDAC_REG_EN_TWO, 8'hc4);
		chk(10'({blk_en_hp, low_power}), 10'h006);
		r = 8'($urandom);
		w(`JDAC_REG_EN_ONE, r);
		chk({blk_en_hp, blk_en_one}, exp_en(2'h0, {2'b11, r}));
		rc(`JDAC_REG_EN_ONE, r);
		w(`JDAC_REG_BTNCLK, 8'h01);
		rc(`JDAC_REG_BTNCLK, 8'h00);
		w(`JDAC_REG_UNLOCK, `JDAC_UNLOCK_KEY);
		w(`JDAC_REG_BTNCLK, 8'h01);
		w(`JDAC_REG_UNLOCK, 8'h00);
		w(`JDAC_REG_BTNCLK, 8'h5a);
		rc(`JDAC_REG_BTNCLK, 8'h01);
		chk(10'(button_clock_setting), 10'h001);
		w(`JDAC_REG_RSVD, 8'hff);
		rc(`JDAC_REG_RSVD, 8'h00);
		core_supply_ok = 1'b0;
		repeat (5) @(negedge ref_clk);
		jdac_host_i.wr(`JDAC_REG_EN_TWO, 8'h01, ok);
		chk(10'(ok), 10'h0);
		{core_supply_ok, mic_supply} = 2'b10;
		repeat (20) @(negedge ref_clk);
		n = pulses;
		mic_supply = 1'b1;
		repeat (12) @(negedge ref_clk);
		chk(10'(pulses), 10'(n + 1));
		rc(`JDAC_REG_EN_TWO, 8'hc4);
		rc(`JDAC_REG_BTNCLK, 8'h01);
		tally_and_finish();
	end
endmodule : jdac_ctrl_tb
